// ---- design/gmcd_top.sv ----
// Purpose: decodes accepted bus bytes into commands, address state
//          and listened data
// Assumes: BYTE_TAKEN, DATA_IN, ATN and PRIMARY_ADDR come from the
//          handshake logic on CLK; IFC_PIN comes straight off the bus
// Notes:   command outputs are one-cycle pulses, states are levels
//          IFC_PIN reaches the roles three cycles after the pin
`timescale 1ns/1ns
module gmcd_top #(
    parameter int DATA_W = 8                // bus data width
) (
    input  wire logic              CLK,          // 250 MHz system clock
    input  wire logic              RESET,        // sync, active high
    input  wire logic              BYTE_TAKEN,   // accept strobe, 1 cycle
    input  wire logic [DATA_W-1:0] DATA_IN,      // byte held with strobe
    input  wire logic              ATN,          // attention with byte
    input  wire logic              IFC_PIN,      // interface clear, async
    input  wire logic [4:0]        PRIMARY_ADDR, // device primary address
    output logic                   LISTENING,    // addressed to listen
    output logic                   TALKING,      // addressed to talk
    output logic [DATA_W-1:0]      DATA_OUT,     // listened data byte
    output logic                   DATA_VALID,   // pulse with DATA_OUT
    output logic                   GO_LOCAL,     // pulse
    output logic                   SEL_CLEAR,    // pulse
    output logic                   TRIGGER,      // pulse
    output logic                   DEV_CLEAR,    // pulse
    output logic                   LOCKOUT,      // level, set by lockout
    output logic                   POLL_MODE     // level, serial poll
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    // at least eight bits are needed, seven of them code bits; wider buses just carry extra bits
    // primary address 31 is not checked here: its listen and talk
    // codes would collide with unlisten and untalk, so the bus
    // controller must never hand it out
    if (DATA_W < 8) begin : g_bad_width
        $error("gmcd_top: DATA_W must be at least 8");
    end

    // ------------------------------------------------------------
    // state of the module
    // ------------------------------------------------------------
    // every flop of the module sits in this one record, so the
    // reset branch and the next-state copy can never drift apart
    typedef struct packed {
        logic                   ifc_s1;     // sync stage one
        logic                   ifc_s2;     // sync stage two
        gmcd_pkg::gmcd_lstate_t lstate;     // listener state
        gmcd_pkg::gmcd_tstate_t tstate;     // talker state
        logic [DATA_W-1:0]      data;       // last listened byte
        logic                   data_vld;   // data strobe
        logic                   gtl;        // go-to-local strobe
        logic                   sdc;        // selective clear strobe
        logic                   get;        // trigger strobe
        logic                   dcl;        // device clear strobe
        logic                   llo;        // lockout level
        logic                   spoll;      // serial poll level
    } gmcd_state_t;

    gmcd_state_t st_r;     // registered state
    gmcd_state_t st_nxt;   // next state

    // ------------------------------------------------------------
    // classifier
    // ------------------------------------------------------------
    // the classifier is combinational: the byte and its meaning are
    // both valid in the strobe cycle and nowhere else
    gmcd_cls_if cls_bus ();

    assign cls_bus.code    = DATA_IN[6:0];
    assign cls_bus.my_addr = PRIMARY_ADDR;

    gmcd_classify u_cls (
        .c (cls_bus.cls)
    );

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    logic cmd_take;   // command byte accepted this cycle
    logic dat_take;   // data byte accepted this cycle

    // one evaluation per strobe, attention read in the same cycle;
    // a strobe held for two cycles counts as two bytes, so the
    // handshake logic must drop it between bytes
    assign cmd_take = BYTE_TAKEN && ATN;
    assign dat_take = BYTE_TAKEN && !ATN;

    always_comb begin
        st_nxt = st_r;
        // strobes last exactly one cycle
        st_nxt.data_vld = 1'b0;
        st_nxt.gtl      = 1'b0;
        st_nxt.sdc      = 1'b0;
        st_nxt.get      = 1'b0;
        st_nxt.dcl      = 1'b0;
        // interface clear pin is read only after two flops
        st_nxt.ifc_s1   = IFC_PIN;
        st_nxt.ifc_s2   = st_r.ifc_s1;

        // clear, command and data are mutually exclusive: at most
        // one of the three branches below changes the roles
        if (st_r.ifc_s2) begin
            // clear wins over any byte taken in the same cycle;
            // lockout and poll mode are not part of the clear
            st_nxt.lstate = gmcd_pkg::GMCD_L_IDLE;
            st_nxt.tstate = gmcd_pkg::GMCD_T_IDLE;
        end else if (cmd_take) begin
            case (cls_bus.cmd)
                gmcd_pkg::GMCD_CMD_UNL: begin
                    // unlisten leaves the talker role untouched
                    st_nxt.lstate = gmcd_pkg::GMCD_L_IDLE;
                end
                gmcd_pkg::GMCD_CMD_UNT: begin
                    // untalk leaves the listener role untouched
                    st_nxt.tstate = gmcd_pkg::GMCD_T_IDLE;
                end
                gmcd_pkg::GMCD_CMD_MLA: begin
                    // own listen address: talker role unchanged
                    st_nxt.lstate = gmcd_pkg::GMCD_L_ADDR;
                end
                gmcd_pkg::GMCD_CMD_MTA: begin
                    // own talk address: listener role unchanged
                    st_nxt.tstate = gmcd_pkg::GMCD_T_ADDR;
                end
                gmcd_pkg::GMCD_CMD_OTA: begin
                    // one talker on the bus: another talk address
                    // silences this device
                    st_nxt.tstate = gmcd_pkg::GMCD_T_IDLE;
                end
                gmcd_pkg::GMCD_CMD_GTL: begin
                    // addressed: only while addressed to listen
                    st_nxt.gtl = (st_r.lstate == gmcd_pkg::GMCD_L_ADDR);
                end
                gmcd_pkg::GMCD_CMD_SDC: begin
                    st_nxt.sdc = (st_r.lstate == gmcd_pkg::GMCD_L_ADDR);
                end
                gmcd_pkg::GMCD_CMD_GET: begin
                    // trigger obeys the same listen gate, though some
                    // hosts send it without addressing first
                    st_nxt.get = (st_r.lstate == gmcd_pkg::GMCD_L_ADDR);
                end
                gmcd_pkg::GMCD_CMD_LLO: begin
                    // only reset clears lockout; go-to-local pulses
                    // and leaves the level for the instrument logic
                    st_nxt.llo = 1'b1;   // universal
                end
                gmcd_pkg::GMCD_CMD_DCL: begin
                    st_nxt.dcl = 1'b1;   // universal
                end
                gmcd_pkg::GMCD_CMD_SPE: begin
                    // poll mode is a level, held until disable
                    st_nxt.spoll = 1'b1;
                end
                gmcd_pkg::GMCD_CMD_SPD: begin
                    st_nxt.spoll = 1'b0;
                end
                gmcd_pkg::GMCD_CMD_SEC: begin
                    // no secondary addressing here
                    st_nxt = st_nxt;
                end
                default: begin
                    // other listen addresses and unknown codes:
                    // leave state alone so other listeners can join
                    st_nxt = st_nxt;
                end
            endcase
        end else if (dat_take) begin
            // command strings pass through byte by byte; parsing of
            // the characters is left to the instrument logic
            // unaddressed data leaves DATA_OUT and the strobe alone
            if (st_r.lstate == gmcd_pkg::GMCD_L_ADDR) begin
                st_nxt.data     = DATA_IN;
                st_nxt.data_vld = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // synchronous reset to constants only; the synchroniser is
    // cleared too, so a clear seen during reset is dropped
    always_ff @(posedge CLK) begin
        if (RESET) begin
            st_r.ifc_s1   <= 1'b0;
            st_r.ifc_s2   <= 1'b0;
            st_r.lstate   <= gmcd_pkg::GMCD_L_IDLE;
            st_r.tstate   <= gmcd_pkg::GMCD_T_IDLE;
            st_r.data     <= DATA_W'(gmcd_pkg::RST_DATA);
            st_r.data_vld <= 1'b0;
            st_r.gtl      <= 1'b0;
            st_r.sdc      <= 1'b0;
            st_r.get      <= 1'b0;
            st_r.dcl      <= 1'b0;
            st_r.llo      <= gmcd_pkg::RST_LOCKOUT;
            st_r.spoll    <= gmcd_pkg::RST_POLL_MODE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs, all straight from flops
    // ------------------------------------------------------------
    // pulses last exactly one cycle after their byte; a consumer
    // that needs longer must stretch them itself
    assign LISTENING  = (st_r.lstate == gmcd_pkg::GMCD_L_ADDR);
    assign TALKING    = (st_r.tstate == gmcd_pkg::GMCD_T_ADDR);
    assign DATA_OUT   = st_r.data;
    assign DATA_VALID = st_r.data_vld;
    assign GO_LOCAL   = st_r.gtl;
    assign SEL_CLEAR  = st_r.sdc;
    assign TRIGGER    = st_r.get;
    assign DEV_CLEAR  = st_r.dcl;
    assign LOCKOUT    = st_r.llo;
    assign POLL_MODE  = st_r.spoll;

endmodule : gmcd_top

// ---- design/gmcd_pkg.sv ----
// Purpose: shared constants and types of the multiline command decoder
// Assumes: seven-bit command codes on an eight-bit data bus
// Notes:   every code, group base and reset value lives here only
//
// Summary of operation
// - command bytes count only while attention asserted
// - unlisten 0x3F sends listener to idle
// - untalk 0x5F sends talker to idle
// - attention-free bytes are data, only when listening
// - decode addressed codes 0x01, 0x04, 0x08
// - decode universal codes 0x11, 0x14, 0x18, 0x19
// - classify listen, talk and secondary groups
// - addressed commands act only while addressed to listen
// - command strings arrive as listened data bytes
// - match addresses against primary address plus base
// - secondary command bytes are ignored
// - interface clear idles both talker and listener
package gmcd_pkg;

    // ------------------------------------------------------------
    // command codes, compared on the low seven bits
    // ------------------------------------------------------------
    localparam logic [6:0] CODE_GO_LOCAL     = 7'h01; // addressed
    localparam logic [6:0] CODE_SEL_CLEAR    = 7'h04; // addressed
    localparam logic [6:0] CODE_TRIGGER      = 7'h08; // addressed
    localparam logic [6:0] CODE_LOCKOUT      = 7'h11; // universal
    localparam logic [6:0] CODE_DEV_CLEAR    = 7'h14; // universal
    localparam logic [6:0] CODE_POLL_ENABLE  = 7'h18; // universal
    localparam logic [6:0] CODE_POLL_DISABLE = 7'h19; // universal
    localparam logic [6:0] CODE_UNLISTEN     = 7'h3f; // listen group top
    localparam logic [6:0] CODE_UNTALK       = 7'h5f; // talk group top

    // ------------------------------------------------------------
    // group layout: bits 6:5 select the group, 4:0 the address
    // ------------------------------------------------------------
    localparam int         GROUP_MSB       = 6;
    localparam int         GROUP_LSB       = 5;
    localparam int         ADDR_W          = 5;
    localparam logic [1:0] GROUP_COMMAND   = 2'h0; // 0x00-0x1f
    localparam logic [1:0] GROUP_LISTEN    = 2'h1; // 0x20-0x3f
    localparam logic [1:0] GROUP_TALK      = 2'h2; // 0x40-0x5f
    localparam logic [1:0] GROUP_SECONDARY = 2'h3; // 0x60-0x7f
    localparam logic [6:0] LISTEN_BASE     = 7'h20;
    localparam logic [6:0] TALK_BASE       = 7'h40;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic       RST_POLL_MODE  = 1'b0;
    localparam logic       RST_LOCKOUT    = 1'b0;
    localparam logic [7:0] RST_DATA       = 8'h00;

    // decoded meaning of a command-mode byte
    typedef enum logic [3:0] {
        GMCD_CMD_NONE, GMCD_CMD_GTL, GMCD_CMD_SDC, GMCD_CMD_GET,
        GMCD_CMD_LLO, GMCD_CMD_DCL, GMCD_CMD_SPE, GMCD_CMD_SPD,
        GMCD_CMD_UNL, GMCD_CMD_UNT, GMCD_CMD_MLA, GMCD_CMD_OLA,
        GMCD_CMD_MTA, GMCD_CMD_OTA, GMCD_CMD_SEC
    } gmcd_cmd_t;

    // listener and talker states, gray along idle -> addressed
    typedef enum logic [0:0] {
        GMCD_L_IDLE = 1'b0,
        GMCD_L_ADDR = 1'b1
    } gmcd_lstate_t;

    typedef enum logic [0:0] {
        GMCD_T_IDLE = 1'b0,
        GMCD_T_ADDR = 1'b1
    } gmcd_tstate_t;

endpackage : gmcd_pkg

// ---- design/gmcd_cls_if.sv ----
// Purpose: carries a byte to the classifier and its meaning back
// Assumes: purely combinational path inside one clock domain
// Notes:   used only between the decoder and its classifier
`timescale 1ns/1ns
interface gmcd_cls_if;
    logic [6:0]          code;      // low seven bits of the byte
    logic [4:0]          my_addr;   // primary address of the device
    gmcd_pkg::gmcd_cmd_t cmd;       // decoded meaning

    modport cls (input code, input my_addr, output cmd);
    modport use_side (output code, output my_addr, input cmd);
endinterface : gmcd_cls_if

// ---- design/gmcd_classify.sv ----
// Purpose: maps a command-mode byte to its decoded meaning
// Assumes: caller presents only bytes taken while attention held
// Notes:   pure combinational logic, no state
`timescale 1ns/1ns
module gmcd_classify (
    gmcd_cls_if.cls c
);

    // ------------------------------------------------------------
    // group split and code lookup
    // ------------------------------------------------------------
    logic [1:0] group;   // upper two bits of the seven-bit code
    assign group = c.code[gmcd_pkg::GROUP_MSB:gmcd_pkg::GROUP_LSB];

    // decode once per byte; address match builds the own codes
    always_comb begin
        c.cmd = gmcd_pkg::GMCD_CMD_NONE;
        case (group)
            gmcd_pkg::GROUP_COMMAND: begin
                case (c.code)
                    gmcd_pkg::CODE_GO_LOCAL:     c.cmd = gmcd_pkg::GMCD_CMD_GTL;
                    gmcd_pkg::CODE_SEL_CLEAR:    c.cmd = gmcd_pkg::GMCD_CMD_SDC;
                    gmcd_pkg::CODE_TRIGGER:      c.cmd = gmcd_pkg::GMCD_CMD_GET;
                    gmcd_pkg::CODE_LOCKOUT:      c.cmd = gmcd_pkg::GMCD_CMD_LLO;
                    gmcd_pkg::CODE_DEV_CLEAR:    c.cmd = gmcd_pkg::GMCD_CMD_DCL;
                    gmcd_pkg::CODE_POLL_ENABLE:  c.cmd = gmcd_pkg::GMCD_CMD_SPE;
                    gmcd_pkg::CODE_POLL_DISABLE: c.cmd = gmcd_pkg::GMCD_CMD_SPD;
                    default:                     c.cmd = gmcd_pkg::GMCD_CMD_NONE;
                endcase
            end
            gmcd_pkg::GROUP_LISTEN: begin
                // unlisten sits at the top of the listen group
                if (c.code == gmcd_pkg::CODE_UNLISTEN) begin
                    c.cmd = gmcd_pkg::GMCD_CMD_UNL;
                end else if (c.code ==
                        (gmcd_pkg::LISTEN_BASE | {2'h0, c.my_addr})) begin
                    c.cmd = gmcd_pkg::GMCD_CMD_MLA;
                end else begin
                    c.cmd = gmcd_pkg::GMCD_CMD_OLA;
                end
            end
            gmcd_pkg::GROUP_TALK: begin
                if (c.code == gmcd_pkg::CODE_UNTALK) begin
                    c.cmd = gmcd_pkg::GMCD_CMD_UNT;
                end else if (c.code ==
                        (gmcd_pkg::TALK_BASE | {2'h0, c.my_addr})) begin
                    c.cmd = gmcd_pkg::GMCD_CMD_MTA;
                end else begin
                    c.cmd = gmcd_pkg::GMCD_CMD_OTA;
                end
            end
            default: c.cmd = gmcd_pkg::GMCD_CMD_SEC;
        endcase
    end

endmodule : gmcd_classify

// ---- test/gmcd_props.sv ----
// Purpose: concurrent checks on the decoder top ports
// Assumes: one clock domain, sync reset, bytes away from clear
// Notes:   bound into every gmcd_top instance
`timescale 1ns/1ns
module gmcd_props #(
    parameter int DATA_W = 8
) (
    input wire logic              CLK,
    input wire logic              RESET,
    input wire logic              BYTE_TAKEN,
    input wire logic [DATA_W-1:0] DATA_IN,
    input wire logic              ATN,
    input wire logic              IFC_PIN,
    input wire logic [4:0]        PRIMARY_ADDR,
    input wire logic              LISTENING,
    input wire logic              TALKING,
    input wire logic [DATA_W-1:0] DATA_OUT,
    input wire logic              DATA_VALID,
    input wire logic              GO_LOCAL,
    input wire logic              SEL_CLEAR,
    input wire logic              TRIGGER,
    input wire logic              DEV_CLEAR,
    input wire logic              LOCKOUT,
    input wire logic              POLL_MODE
);
    // ----------------------------------------------------------
    // helper: the clear synchroniser can hold a pulse
    // ----------------------------------------------------------
    logic [3:0] ifc_hist_r; // clear pin history, newest in bit 0
    logic       quiet;      // no clear pending in the sync chain
    logic       cmd_ok;     // command byte taken while quiet
    logic [6:0] code7;      // command bits, bit 7 ignored
    // history is only a qualifier, so it needs no reset
    always_ff @(posedge CLK) begin
        ifc_hist_r <= {ifc_hist_r[2:0], IFC_PIN};
    end
    assign quiet  = !IFC_PIN && (ifc_hist_r == 4'h0);
    assign cmd_ok = BYTE_TAKEN && ATN && quiet;
    assign code7  = DATA_IN[6:0];

    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);

    // ----------------------------------------------------------
    // interface clear: seen, then both roles idle
    // ----------------------------------------------------------
    sequence ifc_seen;
        IFC_PIN;
    endsequence
    sequence both_idle;
        !LISTENING && !TALKING;
    endsequence

    chk_unlisten_idle: assert property (
        cmd_ok && code7 == 7'h3f |=> !LISTENING) else $error("unlisten");
    chk_untalk_idle: assert property (
        cmd_ok && code7 == 7'h5f |=> !TALKING) else $error("untalk");
    chk_own_listen: assert property (
        cmd_ok && code7 == {2'h1, PRIMARY_ADDR} |=> LISTENING)
        else $error("own listen address");
    chk_own_talk: assert property (
        cmd_ok && code7 == {2'h2, PRIMARY_ADDR} |=> TALKING)
        else $error("own talk address");
    chk_data_pass: assert property (
        BYTE_TAKEN && !ATN && LISTENING && quiet
        |=> DATA_VALID && DATA_OUT == $past(DATA_IN)) else $error("data");
    chk_data_cause: assert property (
        DATA_VALID |-> $past(BYTE_TAKEN && !ATN && LISTENING))
        else $error("stray data");
    chk_addr_gate: assert property (
        GO_LOCAL || SEL_CLEAR || TRIGGER
        |-> $past(BYTE_TAKEN && ATN && LISTENING)) else $error("gate");
    chk_sel_clear: assert property (
        cmd_ok && LISTENING && code7 == 7'h04 |=> SEL_CLEAR && !DEV_CLEAR)
        else $error("selective clear");
    chk_dev_clear: assert property (
        cmd_ok && code7 == 7'h14 |=> DEV_CLEAR) else $error("dev clear");
    chk_poll_mode: assert property (
        cmd_ok && code7[6:1] == 6'h0c |=> POLL_MODE == !$past(DATA_IN[0]))
        else $error("poll mode");
    chk_secondary_skip: assert property (
        cmd_ok && code7[6:5] == 2'h3
        |=> $stable(LISTENING) && $stable(TALKING) && !DATA_VALID)
        else $error("secondary");
    chk_ifc_idle: assert property (
        ifc_seen |-> ##3 both_idle) else $error("interface clear");
endmodule : gmcd_props

bind gmcd_top gmcd_props #(.DATA_W(DATA_W)) u_props (
    .CLK(CLK), .RESET(RESET), .BYTE_TAKEN(BYTE_TAKEN),
    .DATA_IN(DATA_IN), .ATN(ATN), .IFC_PIN(IFC_PIN),
    .PRIMARY_ADDR(PRIMARY_ADDR), .LISTENING(LISTENING),
    .TALKING(TALKING), .DATA_OUT(DATA_OUT), .DATA_VALID(DATA_VALID),
    .GO_LOCAL(GO_LOCAL), .SEL_CLEAR(SEL_CLEAR), .TRIGGER(TRIGGER),
    .DEV_CLEAR(DEV_CLEAR), .LOCKOUT(LOCKOUT), .POLL_MODE(POLL_MODE)
);

// ---- test/gmcd_ctl_model.sv ----
// Purpose: bus controller model handing accepted bytes over
// Assumes: caller stands just after a falling clock edge
// Notes:   released lines flip every cycle so stale bytes show
`timescale 1ns/1ns
module gmcd_ctl_model (
    input  wire logic       clk,
    output logic            byte_taken,
    output logic [7:0]      data,
    output logic            atn,
    output logic            ifc
);
    // idle bus at time zero
    initial begin
        byte_taken = 1'b0;
        data       = 8'h00;
        atn        = 1'b0;
        ifc        = 1'b0;
    end
    // one accepted byte; calls in a row go back to back
    task automatic put(input logic a, input logic [7:0] b);
        byte_taken = 1'b1;
        data       = b;
        atn        = a;
        @(negedge clk);
    endtask : put
    // released bus: data and attention churn, nothing taken
    task automatic rest(input int n);
        byte_taken = 1'b0;
        repeat (n) begin
            data = ~data;
            atn  = ~atn;
            @(negedge clk);
        end
    endtask : rest
    // unlisten first, attention held through the command
    task automatic addr_cmd(input logic [4:0] ad, input logic [7:0] c);
        put(1'b1, 8'h3f);
        put(1'b1, {3'h1, ad});
        put(1'b1, c);
    endtask : addr_cmd
    // one-cycle interface clear
    task automatic clear_bus();
        // the strobe drops so the last byte is not taken again
        byte_taken = 1'b0;
        ifc        = 1'b1;
        @(negedge clk);
        ifc = 1'b0;
    endtask : clear_bus
endmodule : gmcd_ctl_model

// ---- test/gpib_multiline_command_decoder_test.sv ----
// Purpose: self-checking bench of the multiline command decoder
// Assumes: primary address 0x1a then 0x05, inputs on falling edges
// Notes:   row flags: listen talk valid gtl sdc get dcl llo poll
`timescale 1ns/1ns
module gpib_multiline_command_decoder_test;
    logic        clk, reset, byte_taken, atn, ifc;
    logic [7:0]  data_in, data_out;
    logic        listening, talking, data_valid, go_local, sel_clear;
    logic        trigger, dev_clear, lockout, poll_mode;
    logic [4:0]  prim_addr;       // device address under test
    int          error_cnt = 0;   // mismatches seen
    int          checked   = 0;   // comparisons made
    logic [25:0] rows [24];       // atn, byte, flags, data out

    gmcd_top dut (.CLK(clk), .RESET(reset), .BYTE_TAKEN(byte_taken),
        .DATA_IN(data_in), .ATN(atn), .IFC_PIN(ifc),
        .PRIMARY_ADDR(prim_addr), .LISTENING(listening), .TALKING(talking),
        .DATA_OUT(data_out), .DATA_VALID(data_valid),
        .GO_LOCAL(go_local), .SEL_CLEAR(sel_clear), .TRIGGER(trigger),
        .DEV_CLEAR(dev_clear), .LOCKOUT(lockout), .POLL_MODE(poll_mode));
    gmcd_ctl_model ctl (.clk(clk), .byte_taken(byte_taken),
        .data(data_in), .atn(atn), .ifc(ifc));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // compare all outputs at once, settled on a falling edge
    task automatic chk(input logic [16:0] e);
        logic [16:0] g;
        g = {listening, talking, data_valid, go_local, sel_clear,
             trigger, dev_clear, lockout, poll_mode, data_out};
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("Error t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("checked=%0d error_cnt=%0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish

    // ----------------------------------------------------------
    // main sequence: table first, then the awkward cases
    // ----------------------------------------------------------
    initial begin
        rows = '{
            {1'h1, 8'h3f, 9'h000, 8'h00}, {1'h0, 8'h41, 9'h000, 8'h00},
            {1'h1, 8'h01, 9'h000, 8'h00}, {1'h1, 8'h3a, 9'h100, 8'h00},
            {1'h1, 8'h04, 9'h110, 8'h00}, {1'h1, 8'h01, 9'h120, 8'h00},
            {1'h1, 8'h08, 9'h108, 8'h00}, {1'h0, 8'h52, 9'h140, 8'h52},
            {1'h0, 8'h30, 9'h140, 8'h30}, {1'h0, 8'h58, 9'h140, 8'h58},
            {1'h1, 8'h75, 9'h100, 8'h58}, {1'h1, 8'h3f, 9'h000, 8'h58},
            {1'h1, 8'h5a, 9'h080, 8'h58}, {1'h1, 8'h11, 9'h082, 8'h58},
            {1'h1, 8'h14, 9'h086, 8'h58}, {1'h1, 8'h18, 9'h083, 8'h58},
            {1'h1, 8'h19, 9'h082, 8'h58}, {1'h1, 8'h5f, 9'h002, 8'h58},
            {1'h1, 8'h3b, 9'h002, 8'h58}, {1'h1, 8'hba, 9'h102, 8'h58},
            {1'h0, 8'h04, 9'h142, 8'h04}, {1'h1, 8'h04, 9'h112, 8'h04},
            {1'h1, 8'h5a, 9'h182, 8'h04}, {1'h1, 8'h45, 9'h102, 8'h04}};
        reset = 1'b1;
        prim_addr = 5'h1a;
        repeat (5) @(negedge clk);
        reset = 1'b0;
        chk(17'h00000);
        ctl.rest(1);
        // every row back to back, answer one edge later
        foreach (rows[i]) begin
            ctl.put(rows[i][25], rows[i][24:17]);
            chk(rows[i][16:0]);
        end
        $display("table rows done");
        // churning lines without a strobe change nothing
        ctl.rest(3);
        chk({9'h102, 8'h04});
        $display("idle bus done");
        // talker and listener both addressed, then cleared
        ctl.put(1'b1, 8'h5a);
        chk({9'h182, 8'h04});
        ctl.clear_bus();
        // one edge after the clear a byte still lands; the next one
        // meets the synchronised clear and must be dropped
        ctl.put(1'b1, 8'h3a);
        ctl.put(1'b1, 8'h3a);
        ctl.rest(3);
        chk({9'h002, 8'h04});
        $display("interface clear done");
        // mid-run reset drops the lockout level too
        reset = 1'b1;
        ctl.rest(2);
        reset = 1'b0;
        chk(17'h00000);
        ctl.rest(1);
        $display("reset done");
        // full addressed sequence, then a command string
        ctl.addr_cmd(5'h1a, 8'h04);
        chk({9'h110, 8'h00});
        ctl.rest(1);
        ctl.put(1'b0, 8'h52);
        chk({9'h140, 8'h52});
        ctl.rest(2);
        $display("addressed sequence done");
        // a new primary address: the old listen code is foreign now
        prim_addr = 5'h05;
        ctl.addr_cmd(5'h1a, 8'h08);
        chk({9'h000, 8'h52});
        ctl.addr_cmd(5'h05, 8'h08);
        chk({9'h108, 8'h52});
        ctl.rest(2);
        $display("second address done");
        tally_and_finish();
    end

    // watchdog: a stalled run is counted and closed
    initial begin
        repeat (2000) @(posedge clk);
        error_cnt++;
        $display("Error t=%0t run did not finish", $time);
        tally_and_finish();
    end
endmodule : gpib_multiline_command_decoder_test
